//--- cdhc_map.svh
// Constant map for the CD host control and status pin block
`ifndef CDHC_MAP_SVH
`define CDHC_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define CDHC_CLK_HZ          20000000
`define CDHC_LOCK_RATE_HZ    460
`define CDHC_LOCK_LOW_LAST   3'h7

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define CDHC_CMD_W           24
`define CDHC_SUBQ_W          80
`define CDHC_SENSE_W         8
`define CDHC_AUDIO_W         16

// ----------------------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------------------
`define CDHC_CMD_MONSEL_LO   0
`define CDHC_CMD_MONSEL_HI   1
`define CDHC_CMD_LOCKIN      2
`define CDHC_CMD_RESET       24'h000000

// ----------------------------------------------------------------------------
// APB register offsets and status bits
// ----------------------------------------------------------------------------
`define CDHC_REG_CMD         12'h000
`define CDHC_REG_STATUS      12'h004
`define CDHC_ST_LOCK         0
`define CDHC_ST_SYNCF        1
`define CDHC_ST_MUTE         2
`define CDHC_ST_LOCKIN       3
`define CDHC_ST_MONSEL_LO    4
`define CDHC_ST_MONSEL_HI    5
`define CDHC_ST_FSG          6
`define CDHC_ST_INRESET      7

// ----------------------------------------------------------------------------
// Synchronised pin indices and reset levels
// ----------------------------------------------------------------------------
`define CDHC_NPINS           8
`define CDHC_PIN_SHCLK       0
`define CDHC_PIN_DATA        1
`define CDHC_PIN_LATCH_N     2
`define CDHC_PIN_SUBQCLK     3
`define CDHC_PIN_SENSECLK    4
`define CDHC_PIN_MUTE        5
`define CDHC_PIN_SYSRST_N    6
`define CDHC_PIN_LOCK        7
`define CDHC_PIN_RESET_VALS  8'h04

`endif

//--- cdhc_pkg.sv
// Types shared by the CD host control and status pin block
`include "cdhc_map.svh"

package cdhc_pkg;

  typedef enum logic [1:0] {
    CDHC_MON_DEFAULT  = 2'h0,
    CDHC_MON_INTERNAL = 2'h1,
    CDHC_MON_FRAME    = 2'h2,
    CDHC_MON_RSVD     = 2'h3
  } cdhc_monsel_e;

  typedef logic [`CDHC_CMD_W-1:0] cdhc_cmd_t;

endpackage

//--- cdhc_sync3.sv
// Three-flop pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none

module cdhc_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic pclk,     // System clock
  input  wire logic presetn,  // Async reset, active low
  input  wire logic pin,      // Asynchronous pin level
  output logic      level,    // Filtered level
  output logic      rise,     // One-cycle pulse on rising change
  output logic      fall      // One-cycle pulse on falling change
);

  logic ff1;
  logic ff2;
  logic ff3;
  logic next_level;

  // --------------------------------------------------------------------------
  // Change counts once second and third flops agree
  // --------------------------------------------------------------------------
  always_comb begin
    next_level = (ff2 == ff3) ? ff3 : level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff1   <= RESET_VAL;
      ff2   <= RESET_VAL;
      ff3   <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      ff1   <= pin;
      ff2   <= ff1;
      ff3   <= ff2;
      level <= next_level;
    end
  end

  assign rise = next_level & ~level;
  assign fall = ~next_level & level;

endmodule // cdhc_sync3

`default_nettype wire

//--- cdhc_top.sv
// CD host control and status pins: serial command, readout, lock, monitor mux
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cdhc_map.svh"

module cdhc_top #(
  parameter int LOCK_SAMPLE_CYCLES = `CDHC_CLK_HZ / `CDHC_LOCK_RATE_HZ,
  parameter int CMD_W              = `CDHC_CMD_W,
  parameter int SUBQ_W             = `CDHC_SUBQ_W,
  parameter int SENSE_W            = `CDHC_SENSE_W,
  parameter int AUDIO_W            = `CDHC_AUDIO_W
) (
  input  wire logic               pclk,                   // System clock, 20 MHz
  input  wire logic               presetn,                // Async reset, active low
  input  wire logic               psel,                   // APB select
  input  wire logic               penable,                // APB enable
  input  wire logic               pwrite,                 // APB direction
  input  wire logic [11:0]        paddr,                  // APB byte address
  input  wire logic [31:0]        pwdata,                 // APB write data
  output logic      [31:0]        prdata,                 // APB read data
  output logic                    pready,                 // APB ready
  output logic                    pslverr,                // APB error, unmapped
  input  wire logic               system_reset_n,         // System reset pin
  input  wire logic               mute_in,                // Mute pin
  input  wire logic               cmd_data,               // Serial command data pin
  input  wire logic               cmd_shift_clock,        // Serial command clock pin
  input  wire logic               cmd_latch_n,            // Command latch pin
  input  wire logic               subq_readout_clock,     // Subq readout clock pin
  output logic                    subq_serial_out,        // Subq serial data pin
  input  wire logic               sense_readout_clock,    // Sense readout clock pin
  output logic                    sense_out,              // Sense serial data pin
  input  wire logic               lock_i,                 // Lock pin input side
  output logic                    lock_o,                 // Lock pin output side
  output logic                    lock_oe_n,              // Lock pin enable, low drives
  output logic                    lock_status,            // Lock level seen by core
  input  wire logic               subq_load,              // Load readout word
  input  wire logic [SUBQ_W-1:0]  subq_word,              // Readout word
  input  wire logic               sense_load,             // Load sense word
  input  wire logic [SENSE_W-1:0] sense_word,             // Sense word
  input  wire logic               sync_s0,                // Subcode sync S0 found
  input  wire logic               sync_s1,                // Subcode sync S1 found
  input  wire logic               frame_sync_found,       // Frame sync detected
  input  wire logic               insertion_match,        // Expected insertion timing
  output logic                    subcode_sync_flag,      // Subcode sync flag pin
  output logic                    frame_sync_good,        // Frame sync good
  input  wire logic [AUDIO_W-1:0] audio_in,               // Audio sample in
  output logic      [AUDIO_W-1:0] audio_out,              // Audio sample out
  input  wire logic               raw_frame_sync_n,       // Monitor source
  input  wire logic               inverted_pll_clock,     // Monitor source
  input  wire logic               c2_error_pointer,       // Monitor source
  input  wire logic               monitor_sig_0,          // Monitor source
  input  wire logic               monitor_sig_1,          // Monitor source
  input  wire logic               monitor_sig_3,          // Monitor source
  input  wire logic               crystal_frame_clock,    // Monitor source
  input  wire logic               jitter_buffer_overflow, // Monitor source
  input  wire logic               sync_window_open,       // Monitor source
  output logic      [3:0]         monitor_pins            // Monitor pins 3..0
);

  localparam int TW = $clog2(LOCK_SAMPLE_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(LOCK_SAMPLE_CYCLES - 1);

  // --------------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------------
  if (LOCK_SAMPLE_CYCLES < 2 || CMD_W < 3 || CMD_W > 32 || SUBQ_W < 2 ||
      SENSE_W < 2 || AUDIO_W < 1) begin : g_bad_param
    $error("cdhc_top: parameter out of range");
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [`CDHC_NPINS-1:0] pins;
  logic [`CDHC_NPINS-1:0] pin_lvl;
  logic [`CDHC_NPINS-1:0] pin_rise;
  logic [`CDHC_NPINS-1:0] pin_fall;
  localparam logic [`CDHC_NPINS-1:0] PIN_RST = `CDHC_PIN_RESET_VALS;

  always_comb begin
    pins                       = '0;
    pins[`CDHC_PIN_SHCLK]      = cmd_shift_clock;
    pins[`CDHC_PIN_DATA]       = cmd_data;
    pins[`CDHC_PIN_LATCH_N]    = cmd_latch_n;
    pins[`CDHC_PIN_SUBQCLK]    = subq_readout_clock;
    pins[`CDHC_PIN_SENSECLK]   = sense_readout_clock;
    pins[`CDHC_PIN_MUTE]       = mute_in;
    pins[`CDHC_PIN_SYSRST_N]   = system_reset_n;
    pins[`CDHC_PIN_LOCK]       = lock_i;
  end

  for (genvar i = 0; i < `CDHC_NPINS; i++) begin : g_sync
    cdhc_sync3 #(
      .RESET_VAL (PIN_RST[i])
    ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (pins[i]),
      .level   (pin_lvl[i]),
      .rise    (pin_rise[i]),
      .fall    (pin_fall[i])
    );
  end

  logic srst;
  assign srst = ~pin_lvl[`CDHC_PIN_SYSRST_N];

  // --------------------------------------------------------------------------
  // Command shift register and latch, plus APB write of the command
  // --------------------------------------------------------------------------
  logic [CMD_W-1:0] cmd_shift;
  logic [CMD_W-1:0] cmd_word;
  logic [CMD_W-1:0] next_cmd_shift;
  logic [CMD_W-1:0] next_cmd_word;
  logic             apb_wr;
  logic             apb_rd_setup;

  assign apb_wr       = psel & penable & pwrite;
  assign apb_rd_setup = psel & ~penable;

  always_comb begin
    next_cmd_shift = cmd_shift;
    next_cmd_word  = cmd_word;
    if (srst) begin
      next_cmd_shift = '0;
      next_cmd_word  = CMD_W'(`CDHC_CMD_RESET);
    end else begin
      if (pin_rise[`CDHC_PIN_SHCLK]) begin
        next_cmd_shift = {cmd_shift[CMD_W-2:0], pin_lvl[`CDHC_PIN_DATA]};
      end
      if (pin_fall[`CDHC_PIN_LATCH_N]) begin
        next_cmd_word = cmd_shift;
      end else if (apb_wr && paddr == `CDHC_REG_CMD) begin
        next_cmd_word = pwdata[CMD_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_shift <= '0;
      cmd_word  <= CMD_W'(`CDHC_CMD_RESET);
    end else begin
      cmd_shift <= next_cmd_shift;
      cmd_word  <= next_cmd_word;
    end
  end

  cdhc_pkg::cdhc_monsel_e monsel;
  logic                   lock_sel;
  assign monsel   = cdhc_pkg::cdhc_monsel_e'({cmd_word[`CDHC_CMD_MONSEL_HI], cmd_word[`CDHC_CMD_MONSEL_LO]});
  assign lock_sel = cmd_word[`CDHC_CMD_LOCKIN];

  // --------------------------------------------------------------------------
  // Frame sync good and lock detector
  // --------------------------------------------------------------------------
  logic          fsg;
  logic          lock_q;
  logic [TW-1:0] tick_cnt;
  logic [2:0]    low_cnt;
  logic          tick;
  logic          next_fsg;
  logic          next_lock;
  logic [TW-1:0] next_tick_cnt;
  logic [2:0]    next_low_cnt;

  assign tick = (tick_cnt == TICK_LAST);

  always_comb begin
    next_fsg      = frame_sync_found & insertion_match;
    next_lock     = lock_q;
    next_low_cnt  = low_cnt;
    next_tick_cnt = tick ? '0 : tick_cnt + TW'(1);
    if (tick) begin
      if (fsg) begin
        next_lock    = 1'b1;
        next_low_cnt = '0;
      end else if (low_cnt == `CDHC_LOCK_LOW_LAST) begin
        next_lock    = 1'b0;
      end else begin
        next_low_cnt = low_cnt + 3'h1;
      end
    end
    if (srst) begin
      next_fsg      = 1'b0;
      next_lock     = 1'b0;
      next_low_cnt  = '0;
      next_tick_cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsg      <= 1'b0;
      lock_q   <= 1'b0;
      tick_cnt <= '0;
      low_cnt  <= '0;
    end else begin
      fsg      <= next_fsg;
      lock_q   <= next_lock;
      tick_cnt <= next_tick_cnt;
      low_cnt  <= next_low_cnt;
    end
  end

  assign lock_o          = lock_q;
  assign lock_oe_n       = lock_sel;
  assign lock_status     = lock_sel ? pin_lvl[`CDHC_PIN_LOCK] : lock_q;
  assign frame_sync_good = fsg;

  // --------------------------------------------------------------------------
  // Serial readout of subq and sense words, MSB first
  // --------------------------------------------------------------------------
  logic [SUBQ_W-1:0]  subq_sr;
  logic [SENSE_W-1:0] sense_sr;
  logic [SUBQ_W-1:0]  next_subq_sr;
  logic [SENSE_W-1:0] next_sense_sr;

  always_comb begin
    next_subq_sr  = subq_sr;
    next_sense_sr = sense_sr;
    if (srst) begin
      next_subq_sr  = '0;
      next_sense_sr = '0;
    end else begin
      if (subq_load) begin
        next_subq_sr = subq_word;
      end else if (pin_rise[`CDHC_PIN_SUBQCLK]) begin
        next_subq_sr = {subq_sr[SUBQ_W-2:0], 1'b0};
      end
      if (sense_load) begin
        next_sense_sr = sense_word;
      end else if (pin_rise[`CDHC_PIN_SENSECLK]) begin
        next_sense_sr = {sense_sr[SENSE_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subq_sr  <= '0;
      sense_sr <= '0;
    end else begin
      subq_sr  <= next_subq_sr;
      sense_sr <= next_sense_sr;
    end
  end

  assign subq_serial_out = subq_sr[SUBQ_W-1];
  assign sense_out       = sense_sr[SENSE_W-1];

  // --------------------------------------------------------------------------
  // Pin outputs: sync flag, mute, monitor mux
  // --------------------------------------------------------------------------
  logic               next_syncf;
  logic [AUDIO_W-1:0] next_audio;
  logic [3:0]         next_mon;

  always_comb begin
    next_syncf = sync_s0 | sync_s1;
    next_audio = pin_lvl[`CDHC_PIN_MUTE] ? '0 : audio_in;
    case (monsel)
      cdhc_pkg::CDHC_MON_INTERNAL: next_mon = {monitor_sig_1, monitor_sig_0, monitor_sig_3, c2_error_pointer};
      cdhc_pkg::CDHC_MON_FRAME:    next_mon = {crystal_frame_clock, inverted_pll_clock,
                                               jitter_buffer_overflow, sync_window_open};
      default:                     next_mon = {raw_frame_sync_n, inverted_pll_clock, fsg, c2_error_pointer};
    endcase
    if (srst) begin
      next_syncf = 1'b0;
      next_audio = '0;
      next_mon   = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subcode_sync_flag <= 1'b0;
      audio_out         <= '0;
      monitor_pins      <= '0;
    end else begin
      subcode_sync_flag <= next_syncf;
      audio_out         <= next_audio;
      monitor_pins      <= next_mon;
    end
  end

  // --------------------------------------------------------------------------
  // APB slave: zero wait states, read data captured in setup cycle
  // --------------------------------------------------------------------------
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [31:0] status;

  always_comb begin
    status                      = '0;
    status[`CDHC_ST_LOCK]       = lock_status;
    status[`CDHC_ST_SYNCF]      = subcode_sync_flag;
    status[`CDHC_ST_MUTE]       = pin_lvl[`CDHC_PIN_MUTE];
    status[`CDHC_ST_LOCKIN]     = lock_sel;
    status[`CDHC_ST_MONSEL_LO]  = cmd_word[`CDHC_CMD_MONSEL_LO];
    status[`CDHC_ST_MONSEL_HI]  = cmd_word[`CDHC_CMD_MONSEL_HI];
    status[`CDHC_ST_FSG]        = fsg;
    status[`CDHC_ST_INRESET]    = srst;
  end

  always_comb begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (apb_rd_setup) begin
      next_prdata  = '0;
      next_pslverr = 1'b0;
      if (paddr == `CDHC_REG_CMD) begin
        next_prdata = 32'(cmd_word);
      end else if (paddr == `CDHC_REG_STATUS) begin
        next_prdata = pwrite ? '0 : status;
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  assign pready = 1'b1;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  lock_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && fsg && !srst) |=> lock_q)
    else $error("lock not set on good sample");

  lock_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(lock_q) && !$past(srst)) |-> $past(tick && !fsg && low_cnt == `CDHC_LOCK_LOW_LAST))
    else $error("lock fell before eight low samples");

  lock_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    lock_sel |-> (lock_oe_n && lock_status == pin_lvl[`CDHC_PIN_LOCK]))
    else $error("lock pin driven while input selected");

  cmd_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_fall[`CDHC_PIN_LATCH_N] && !srst) |=> cmd_word == $past(cmd_shift))
    else $error("command not captured on latch fall");

  sys_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    srst |=> (!lock_q && subq_sr == '0 && monitor_pins == 4'h0 && audio_out == '0))
    else $error("logic active during system reset");

  mute_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!srst && !pin_lvl[`CDHC_PIN_MUTE]) |=> audio_out == $past(audio_in))
    else $error("audio wrong while not muted");

  sync_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!srst && (sync_s0 || sync_s1)) |=> subcode_sync_flag)
    else $error("subcode sync flag missed");

  subq_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!srst && !subq_load && pin_rise[`CDHC_PIN_SUBQCLK]) |=> subq_serial_out == $past(subq_sr[SUBQ_W-2]))
    else $error("subq bit did not advance");

  sense_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!srst && !sense_load && pin_rise[`CDHC_PIN_SENSECLK]) |=> sense_out == $past(sense_sr[SENSE_W-2]))
    else $error("sense bit did not advance");

  mon_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!srst && monsel == cdhc_pkg::CDHC_MON_FRAME) |=>
      monitor_pins == $past({crystal_frame_clock, inverted_pll_clock, jitter_buffer_overflow, sync_window_open}))
    else $error("frame monitor set not routed");

  mon_default_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!srst && monsel == cdhc_pkg::CDHC_MON_DEFAULT) |=>
      monitor_pins == $past({raw_frame_sync_n, inverted_pll_clock, fsg, c2_error_pointer}))
    else $error("default monitor set not routed");

  fsg_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!srst && frame_sync_found && insertion_match) |=> frame_sync_good)
    else $error("frame sync good missed");

  reset_dflt_a: assert property (@(posedge pclk) disable iff (!presetn)
    srst |=> (monsel == cdhc_pkg::CDHC_MON_DEFAULT && !lock_oe_n))
    else $error("reset did not restore defaults");

  cmd_msb_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!srst && pin_rise[`CDHC_PIN_SHCLK]) |=> cmd_shift[0] == $past(pin_lvl[`CDHC_PIN_DATA]))
    else $error("command bit not shifted in");

endmodule // cdhc_top

`default_nettype wire

//--- cdhc_host_model.sv
// Host model: serial command writer and readout clocker
`timescale 1ns/1ps
`default_nettype none
module cdhc_host_model (
  input  wire logic pclk,     // System clock
  input  wire logic subq_out, // Subq data
  input  wire logic sense_out, // Sense data
  output logic      data,     // Command data
  output logic      shclk,    // Command clock
  output logic      latch_n,  // Command latch
  output logic      subq_clk, // Subq clock
  output logic      sense_clk // Sense clock
);
  initial begin
    {data, shclk, subq_clk, sense_clk} = 4'h0;
    latch_n = 1'b1;
  end
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      data <= w[i];
      repeat (4) @(posedge pclk);
      shclk <= 1'b1;
      repeat (4) @(posedge pclk);
      shclk <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    latch_n <= 1'b0;
    data <= ~w[0];
    repeat (4) @(posedge pclk);
    latch_n <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  task automatic read(input logic pick, input int n, output logic [79:0] q);
    q = '0;
    for (int i = 0; i < n; i++) begin
      q = {q[78:0], pick ? sense_out : subq_out};
      if (pick) sense_clk <= 1'b1;
      else subq_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      {sense_clk, subq_clk} <= 2'h0;
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule // cdhc_host_model
`default_nettype wire

//--- test_cdhc_top.sv
// Testbench for the CD host control and status pin block
`timescale 1ns/1ps
`default_nettype none
module test_cdhc_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, srst_n, mute, lk_i, lk_o, lk_oe_n, lk_st;
  logic        sq_ld, se_ld, s0, s1, fsf, im, syncf, fsg, d, sc, la, qc, ec, qo, eo;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [79:0] sq_w, q;
  logic [15:0] ai, ao;
  logic [8:0]  m;
  logic [7:0]  se_w;
  logic [3:0]  mp;
  int          err_total, checked, cyc = 0;
  cdhc_top #(.LOCK_SAMPLE_CYCLES(16)) cdhc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .system_reset_n(srst_n), .mute_in(mute), .cmd_data(d), .cmd_shift_clock(sc),
    .cmd_latch_n(la), .subq_readout_clock(qc), .subq_serial_out(qo), .sense_readout_clock(ec), .sense_out(eo),
    .lock_i(lk_i), .lock_o(lk_o), .lock_oe_n(lk_oe_n), .lock_status(lk_st), .subq_load(sq_ld), .subq_word(sq_w),
    .sense_load(se_ld), .sense_word(se_w), .sync_s0(s0), .sync_s1(s1), .frame_sync_found(fsf),
    .insertion_match(im), .subcode_sync_flag(syncf), .frame_sync_good(fsg), .audio_in(ai), .audio_out(ao),
    .raw_frame_sync_n(m[0]), .inverted_pll_clock(m[1]), .c2_error_pointer(m[2]), .monitor_sig_0(m[3]),
    .monitor_sig_1(m[4]), .monitor_sig_3(m[5]), .crystal_frame_clock(m[6]), .jitter_buffer_overflow(m[7]),
    .sync_window_open(m[8]), .monitor_pins(mp));
  cdhc_host_model host_inst (.pclk(pclk), .subq_out(qo), .sense_out(eo), .data(d), .shclk(sc), .latch_n(la),
    .subq_clk(qc), .sense_clk(ec));
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, dat};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_mon();
    rd(12'h004, 32'h0);
    apb(1'b1, 12'h004, 32'hff);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
    chk(pslverr, 1'b1);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 12'h000, 32'(s));
      tick(2);
      chk(mp, 4'(16'h9a19 >> (4 * s)));
      rd(12'h004, 32'(s << 4));
    end
    host_inst.send(24'h000001);
    rd(12'h004, 32'h10);
    host_inst.send(24'h000000);
    $display("monitor test done");
  endtask
  task automatic t_lock();
    {fsf, im} <= 2'h3;
    tick(2);
    chk(fsg, 1'b1);
    tick(40);
    chk({lk_o, lk_st, lk_oe_n}, 3'h6);
    im <= 1'b0;
    tick(90);
    chk(lk_o, 1'b1);
    tick(70);
    chk(lk_o, 1'b0);
    apb(1'b1, 12'h000, 32'h4);
    lk_i <= 1'b1;
    tick(8);
    chk({lk_oe_n, lk_st}, 2'h3);
    lk_i <= 1'b0;
    apb(1'b1, 12'h000, 32'h0);
    tick(2);
    chk(lk_oe_n, 1'b0);
    $display("lock test done");
  endtask
  task automatic t_misc();
    for (int k = 1; k < 3; k++) begin
      {s1, s0} <= 2'(k);
      tick(2);
      chk(syncf, 1'b1);
      {s1, s0} <= 2'h0;
      tick(2);
      chk(syncf, 1'b0);
    end
    ai <= 16'h1234;
    mute <= 1'b1;
    tick(8);
    chk(ao, 16'h0);
    mute <= 1'b0;
    tick(8);
    chk(ao, 16'h1234);
    {sq_ld, se_ld} <= 2'h3;
    tick(1);
    {sq_ld, se_ld} <= 2'h0;
    tick(1);
    host_inst.read(1'b0, 80, q);
    chk(q, sq_w);
    host_inst.read(1'b1, 8, q);
    chk(q, 80'(se_w));
    $display("misc test done");
  endtask
  task automatic t_srst();
    apb(1'b1, 12'h000, 32'h2);
    srst_n <= 1'b0;
    tick(8);
    chk(mp, 4'h0);
    rd(12'h004, 32'h80);
    srst_n <= 1'b1;
    tick(8);
    rd(12'h004, 32'h0);
    chk(mp, 4'h9);
    $display("reset test done");
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, mute, lk_i, sq_ld, se_ld, s0, s1, fsf, im, ai} = '0;
    {srst_n, m, se_w, err_total, checked} = {1'b1, 9'h0c5, 8'hb4, 64'h0};
    sq_w = 80'hc3a5_0f1e_2d3c_4b5a_6978;
    tick(10);
    presetn <= 1'b1;
    tick(6);
    t_mon();
    t_lock();
    t_misc();
    t_srst();
    test_done();
  end
endmodule // test_cdhc_top
`default_nettype wire
